// ==== logic/touch_adc_pkg.sv ====
// Constants, types and field layouts for the touch-screen converter control.
// Assumes one system clock; all pins are sampled synchronously to it.
`default_nettype none

package touch_adc_pkg;

  // System clock
  localparam int          CLK_PERIOD_NS   = 40;

  // Control byte framing: counts are bits received after the start bit
  localparam int          CTRL_BITS       = 8;
  localparam logic [2:0]  BIT_CNT_CHAN    = 3'h2;
  localparam logic [2:0]  BIT_CNT_LAST    = 3'h6;

  // Conversion lengths in serial clocks, and full-scale code span
  localparam int          RES_FULL        = 12;
  localparam int          CODE_STEPS      = 4096;
  localparam logic [3:0]  CONV_STEPS_FULL = 4'hC;
  localparam logic [3:0]  CONV_STEPS_SHORT = 4'h8;

  // Channel codes
  localparam logic [2:0]  CH_X_PLATE      = 3'h1;
  localparam logic [2:0]  CH_Y_PLATE      = 3'h5;
  localparam logic [2:0]  CH_AUX_A        = 3'h2;
  localparam logic [2:0]  CH_AUX_B        = 3'h6;

  // Power-down codes
  localparam logic [1:0]  PD_AUTO_PEN     = 2'h0;
  localparam logic [1:0]  PD_AUTO_QUIET   = 2'h1;
  localparam logic [1:0]  PD_RESERVED     = 2'h2;
  localparam logic [1:0]  PD_ALWAYS_ON    = 2'h3;

  typedef enum logic [1:0] {
    ST_IDLE = 2'h0,
    ST_ACQ  = 2'h1,
    ST_CONV = 2'h3,
    ST_TAIL = 2'h2
  } conv_state_e;

  typedef enum logic [1:0] {
    REF_VREF_GND = 2'h0,
    REF_Y_PLATES = 2'h1,
    REF_X_PLATES = 2'h2
  } ref_route_e;

  // Control byte without its start bit, MSB first
  typedef struct packed {
    logic [2:0] channel_select;
    logic       mode8;
    logic       ref_mode_sel;
    logic [1:0] power_down_sel;
  } ctrl_byte_s;

  localparam ctrl_byte_s CTRL_RESET = '{channel_select: 3'h0, mode8: 1'b0,
                                        ref_mode_sel: 1'b1, power_down_sel: PD_AUTO_PEN};

  // Controls toward the analog front end
  typedef struct packed {
    logic [2:0] mux_sel;
    logic       drive_x;
    logic       drive_y;
    logic       y_neg_only;
    ref_route_e ref_route;
    logic       full_power;
    logic       hold;
  } analog_ctrl_s;

  localparam analog_ctrl_s ANALOG_RESET = '{mux_sel: 3'h0, drive_x: 1'b0, drive_y: 1'b0,
                                            y_neg_only: 1'b1, ref_route: REF_VREF_GND,
                                            full_power: 1'b0, hold: 1'b0};

endpackage

`default_nettype wire

// ==== logic/sclk_edges.sv ====
// Edge detector for the host serial clock.
// Assumes the serial clock is already synchronous to clk_sys.
`timescale 1ns/1ps
`default_nettype none

module sclk_edges (
  // System
  input  wire logic clk_sys,
  input  wire logic srst,
  // Serial clock and its edges
  input  wire logic serial_clock_in,
  output logic      rise,
  output logic      fall
);

  logic prev;

  always_ff @(posedge clk_sys) begin
    if (srst) begin
      prev <= 1'b0;
    end else begin
      prev <= serial_clock_in;
    end
  end

  assign rise = serial_clock_in & ~prev;
  assign fall = ~serial_clock_in & prev;

endmodule // sclk_edges

`default_nettype wire

// ==== logic/sar_engine.sv ====
// Successive-approximation register: trial code toward the DAC, one decision per step.
// Assumes the comparator answer is settled when step is pulsed.
`timescale 1ns/1ps
`default_nettype none

module sar_engine #(
  parameter int WIDTH = 12
) (
  // System
  input  wire logic             clk_sys,
  input  wire logic             srst,
  // Sequencing
  input  wire logic             start,
  input  wire logic             step,
  input  wire logic             cmp_high,
  // Trial code and decisions
  output logic [WIDTH-1:0]      trial,
  output logic [WIDTH-1:0]      mask,
  output logic                  last_bit
);

  always_ff @(posedge clk_sys) begin
    if (srst) begin
      trial    <= '0;
      mask     <= '0;
      last_bit <= 1'b0;
    end else if (start) begin
      trial    <= {1'b1, {(WIDTH-1){1'b0}}};
      mask     <= {1'b1, {(WIDTH-1){1'b0}}};
    end else if (step) begin
      // Keep or drop the bit under test, then try the next lower one
      trial    <= (cmp_high ? trial : (trial & ~mask)) | (mask >> 1);
      mask     <= mask >> 1;
      last_bit <= cmp_high;
    end
  end

endmodule // sar_engine

`default_nettype wire

// ==== logic/touch_adc_serial_control.sv ====
// Serial control byte receiver and conversion sequencer of a touch-screen SAR converter.
// Assumes all pins are synchronous to clk_sys and the serial clock is much slower.
`timescale 1ns/1ps
`default_nettype none

// Function
// - A transfer is eight serial clocks; a full conversion takes 24.
// - Ignore serial input until a high start bit arrives.
// - Byte MSB first: start, channel, resolution, reference, power-down.
// - After channel bits, configure and acquire; hold when byte completes.
// - Twelve-bit conversion spans twelve serial clocks after the byte.
// - Last bit needs a thirteenth clock; filler clocks drive zero.
// - Differential keeps drive switches on in conversion; single-ended drops them.
// - Resolution bit zero gives 12 bits, one gives 8 bits.
// - Reference bit high single-ended, low differential; sets switch configuration.
// - Single-ended reference is pin to ground; differential spans enabled switches.
// - Differential with vertical drivers routes reference to vertical plates.
// - Accept a new overlapping control byte every 15 or 11 clocks.
// - Code 00: power down after conversion, pen interrupt on, lower vertical switch on.
// - Code 01: as 00 but pen interrupt off and lower switch off.
// - Code 11: always powered, pen interrupt off.
// - A new conversion wakes from power-down instantly.
// - Full result is a straight 12-bit code of 4096 steps.
// - Serial input sampled on rising serial clock only while selected.
// - Output shifts on falling serial clock; released while deselected.
// - Single-ended channels select plates or auxiliaries, driving opposite plate or none.
// - Eight-bit conversion finishes four clocks earlier.
module touch_adc_serial_control
  import touch_adc_pkg::*;
#(
  parameter int RES_BITS = RES_FULL
) (
  // System
  input  wire logic                       clk_sys,
  input  wire logic                       srst,
  // Serial link
  input  wire logic                       serial_clock_in,
  input  wire logic                       cs_n,
  input  wire logic                       serial_data_in,
  output logic                            serial_data_out,
  output logic                            serial_data_out_oe,
  output logic                            busy,
  output logic                            busy_oe,
  // Pen interrupt, open drain
  output logic                            touch_irq_n,
  output logic                            touch_irq_n_oe,
  // Analog front end
  input  wire logic                       pen_contact,
  input  wire logic                       cmp_high,
  output touch_adc_pkg::analog_ctrl_s     analog,
  output logic [RES_BITS-1:0]             sar_trial,
  // Result to user logic
  output logic [RES_BITS-1:0]             result,
  output logic                            result_valid
);
  import touch_adc_pkg::*;

  logic                rise;
  logic                fall;
  logic                rx_active;
  logic [2:0]          rx_cnt;
  logic [5:0]          rx_shift;
  logic                chan_seen;
  logic                byte_done;
  ctrl_byte_s          byte_in;
  ctrl_byte_s          acq_cfg;
  ctrl_byte_s          conv_cfg;
  ctrl_byte_s          cfg;
  logic                acq_pend;
  conv_state_e         state;
  conv_state_e         next_state;
  logic [3:0]          conv_cnt;
  logic [3:0]          nbits;
  logic [RES_BITS-1:0] sar_mask;
  logic                sar_bit;
  logic                sw_on;
  logic                pen_en;
  analog_ctrl_s        next_analog;

  sclk_edges u_edges (
    .clk_sys         (clk_sys),
    .srst            (srst),
    .serial_clock_in (serial_clock_in),
    .rise            (rise),
    .fall            (fall)
  );

  // Control byte receiver
  assign chan_seen = rise & ~cs_n & rx_active & (rx_cnt == BIT_CNT_CHAN);
  assign byte_done = rise & ~cs_n & rx_active & (rx_cnt == BIT_CNT_LAST);
  assign byte_in   = ctrl_byte_s'({rx_shift, serial_data_in});

  always_ff @(posedge clk_sys) begin
    if (srst) begin
      rx_active <= 1'b0;
      rx_cnt    <= 3'h0;
      rx_shift  <= 6'h00;
    end else if (cs_n) begin
      rx_active <= 1'b0;
    end else if (rise) begin
      if (!rx_active) begin
        if (serial_data_in) begin
          rx_active <= 1'b1;
          rx_cnt    <= 3'h0;
        end
      end else begin
        rx_shift <= {rx_shift[4:0], serial_data_in};
        rx_cnt   <= rx_cnt + 3'h1;
        if (rx_cnt == BIT_CNT_LAST) begin
          rx_active <= 1'b0;
        end
      end
    end
  end

  // Configuration for the acquisition in progress and the conversion in progress
  always_ff @(posedge clk_sys) begin
    if (srst) begin
      acq_cfg  <= CTRL_RESET;
      conv_cfg <= CTRL_RESET;
    end else begin
      if (chan_seen) begin
        acq_cfg.channel_select <= {rx_shift[1:0], serial_data_in};
      end
      if (byte_done) begin
        acq_cfg <= byte_in;
      end
      if (byte_done && state == ST_ACQ) begin
        conv_cfg <= byte_in;
      end
    end
  end

  // A byte may start while the previous conversion still runs
  always_ff @(posedge clk_sys) begin
    if (srst) begin
      acq_pend <= 1'b0;
    end else if (chan_seen && (state == ST_CONV || state == ST_TAIL)) begin
      acq_pend <= 1'b1;
    end else if (state == ST_TAIL && fall) begin
      acq_pend <= 1'b0;
    end
  end

  assign nbits = conv_cfg.mode8 ? CONV_STEPS_SHORT : CONV_STEPS_FULL;

  // Conversion sequencer
  always_comb begin
    next_state = state;
    case (state)
      ST_IDLE: begin
        if (chan_seen) begin
          next_state = ST_ACQ;
        end
      end
      ST_ACQ: begin
        if (byte_done) begin
          next_state = ST_CONV;
        end else if (cs_n && !acq_pend) begin
          next_state = ST_IDLE;
        end
      end
      ST_CONV: begin
        if (rise && conv_cnt == nbits - 4'h1) begin
          next_state = ST_TAIL;
        end
      end
      ST_TAIL: begin
        if (fall) begin
          next_state = acq_pend ? ST_ACQ : ST_IDLE;
        end
      end
      default: begin
        next_state = ST_IDLE;
      end
    endcase
  end

  always_ff @(posedge clk_sys) begin
    if (srst) begin
      state <= ST_IDLE;
    end else begin
      state <= next_state;
    end
  end

  always_ff @(posedge clk_sys) begin
    if (srst) begin
      conv_cnt <= 4'h0;
    end else if (byte_done && state == ST_ACQ) begin
      conv_cnt <= 4'h0;
    end else if (rise && state == ST_CONV) begin
      conv_cnt <= conv_cnt + 4'h1;
    end
  end

  sar_engine #(
    .WIDTH (RES_BITS)
  ) u_sar (
    .clk_sys  (clk_sys),
    .srst     (srst),
    .start    (byte_done && state == ST_ACQ),
    .step     (rise && state == ST_CONV),
    .cmp_high (cmp_high),
    .trial    (sar_trial),
    .mask     (sar_mask),
    .last_bit (sar_bit)
  );

  // Result shifting and busy, both on the falling serial clock
  always_ff @(posedge clk_sys) begin
    if (srst) begin
      serial_data_out <= 1'b0;
      busy            <= 1'b0;
    end else if (fall) begin
      case (state)
        ST_CONV: begin
          busy            <= 1'b1;
          serial_data_out <= (conv_cnt != 4'h0) ? sar_bit : 1'b0;
        end
        ST_TAIL: begin
          busy            <= 1'b0;
          serial_data_out <= sar_bit;
        end
        default: begin
          busy            <= 1'b0;
          serial_data_out <= 1'b0;
        end
      endcase
    end
  end

  // Pins released while deselected; the pads see no timing hazard at this rate
  assign serial_data_out_oe = ~cs_n;
  assign busy_oe            = ~cs_n;

  // Final code; the bit under test is dropped so 8-bit results end in zeros
  always_ff @(posedge clk_sys) begin
    if (srst) begin
      result       <= '0;
      result_valid <= 1'b0;
    end else begin
      result_valid <= (state == ST_TAIL) && fall;
      if (state == ST_TAIL && fall) begin
        result <= sar_trial & ~sar_mask;
      end
    end
  end

  // Analog front-end configuration
  always_comb begin
    cfg         = (state == ST_ACQ) ? acq_cfg : conv_cfg;
    sw_on       = (state == ST_ACQ) || (state == ST_CONV && !cfg.ref_mode_sel);
    pen_en      = (state == ST_IDLE) && (conv_cfg.power_down_sel == PD_AUTO_PEN);
    next_analog = ANALOG_RESET;
    next_analog.mux_sel    = cfg.channel_select;
    next_analog.drive_y    = sw_on && cfg.channel_select == CH_X_PLATE;
    next_analog.drive_x    = sw_on && cfg.channel_select == CH_Y_PLATE;
    next_analog.y_neg_only = pen_en;
    next_analog.hold       = (state == ST_CONV) || (state == ST_TAIL);
    next_analog.full_power = (state != ST_IDLE) || (conv_cfg.power_down_sel == PD_ALWAYS_ON);
    if (!cfg.ref_mode_sel && cfg.channel_select == CH_X_PLATE) begin
      next_analog.ref_route = REF_Y_PLATES;
    end else if (!cfg.ref_mode_sel && cfg.channel_select == CH_Y_PLATE) begin
      next_analog.ref_route = REF_X_PLATES;
    end else begin
      next_analog.ref_route = REF_VREF_GND;
    end
  end

  always_ff @(posedge clk_sys) begin
    if (srst) begin
      analog         <= ANALOG_RESET;
      touch_irq_n_oe <= 1'b0;
    end else begin
      analog         <= next_analog;
      touch_irq_n_oe <= pen_en && pen_contact;
    end
  end

  assign touch_irq_n = 1'b0;

  // Checks
  default clocking cb @(posedge clk_sys); endclocking
  default disable iff (srst);

  a_start_gate: assert property ($rose(rx_active) |-> $past(serial_data_in) && $past(rise) && !$past(cs_n))
    else $error("receiver started without a high start bit");
  a_cs_abandon: assert property (cs_n |=> !rx_active)
    else $error("receiver still active after deselect");
  a_byte_hold: assert property (byte_done && state == ST_ACQ |=> state == ST_CONV ##1 analog.hold)
    else $error("conversion did not begin at end of control byte");
  a_conv_length: assert property (rise && state == ST_CONV && conv_cnt == nbits - 4'h1 |=> state == ST_TAIL)
    else $error("conversion length wrong");
  a_filler_zero: assert property (fall && (state == ST_IDLE || state == ST_ACQ) |=> !serial_data_out && !busy)
    else $error("filler clock did not drive zero");
  a_single_drop: assert property (state == ST_CONV && conv_cfg.ref_mode_sel |=> !analog.drive_x && !analog.drive_y)
    else $error("drive switches on during single-ended hold");
  a_diff_keep: assert property (state == ST_CONV && !conv_cfg.ref_mode_sel && conv_cfg.channel_select == CH_X_PLATE
                                |=> analog.drive_y && analog.ref_route == REF_Y_PLATES)
    else $error("differential conversion lost vertical drive or reference");
  a_pen_gate: assert property (conv_cfg.power_down_sel != PD_AUTO_PEN |=> !touch_irq_n_oe)
    else $error("pen interrupt driven while disabled");
  a_always_on: assert property (conv_cfg.power_down_sel == PD_ALWAYS_ON && $stable(conv_cfg) |=> analog.full_power)
    else $error("powered down in always-on mode");
  a_busy_end: assert property (state == ST_TAIL && fall |=> !busy && result_valid)
    else $error("busy not released at last bit");
  a_pins_off: assert property (cs_n |-> !serial_data_out_oe && !busy_oe)
    else $error("output driven while deselected");

  c_conv_full: cover property (state == ST_TAIL && fall && !conv_cfg.mode8);
  c_conv_short: cover property (state == ST_TAIL && fall && conv_cfg.mode8);
  c_overlap: cover property (state == ST_TAIL && fall && acq_pend);
  c_pen_irq: cover property (touch_irq_n_oe);

endmodule // touch_adc_serial_control

`default_nettype wire

// ==== tb/serial_host_model.sv ====
// Host serial master model: frames transfers and captures the converter's answers.
// Assumes clk_sys is the only clock; each serial clock phase lasts several clk_sys cycles.
`timescale 1ns/1ps
`default_nettype none

module serial_host_model (
  // System
  input  wire logic clk_sys,
  // Serial link
  output logic      serial_clock_in,
  output logic      cs_n,
  output logic      serial_data_in,
  input  wire logic serial_data_out,
  input  wire logic serial_data_out_oe,
  input  wire logic busy,
  input  wire logic busy_oe,
  // Serial clock count in the current frame
  output int        clk_idx
);
  initial begin
    serial_clock_in = 1'b0;
    cs_n            = 1'b1;
    serial_data_in  = 1'b0;
    clk_idx         = 0;
  end

  // Clocks n bits of tx MSB first; with sel low chip select stays high
  task automatic frame(input logic [39:0] tx, input int n, input logic sel,
                       output logic [39:0] rx, output logic [39:0] bz);
    rx = '0;
    bz = '0;
    @(posedge clk_sys) cs_n <= ~sel;
    for (int i = 0; i < n; i++) begin
      repeat (2) @(posedge clk_sys);
      serial_data_in <= tx[39-i];
      repeat (3) @(posedge clk_sys);
      serial_clock_in <= 1'b1;
      clk_idx         <= i + 1;
      repeat (3) @(posedge clk_sys);
      serial_clock_in <= 1'b0;
      // Read late in the low phase, once the fall has reached the pins
      repeat (4) @(negedge clk_sys);
      rx[39-i] = serial_data_out_oe ? serial_data_out : 1'bx;
      bz[39-i] = busy_oe ? busy : 1'bx;
    end
    @(posedge clk_sys);
    cs_n           <= 1'b1;
    clk_idx        <= 0;
    // Released line shows the inverse so a stale level is never trusted
    serial_data_in <= ~serial_data_in;
  endtask

endmodule // serial_host_model

`default_nettype wire

// ==== tb/touch_adc_serial_control_tb_top.sv ====
// Self-checking bench for the touch converter serial control.
// Assumes the host model clocks the link and a comparator model answers from per-channel levels.
`timescale 1ns/1ps
`default_nettype none

module touch_adc_serial_control_tb_top;
  import touch_adc_pkg::*;

  logic         clk_sys;
  logic         srst;
  logic         serial_clock_in;
  logic         cs_n;
  logic         serial_data_in;
  logic         serial_data_out;
  logic         serial_data_out_oe;
  logic         busy;
  logic         busy_oe;
  logic         touch_irq_n;
  logic         touch_irq_n_oe;
  logic         pen_contact;
  logic         cmp_high;
  analog_ctrl_s analog;
  logic [11:0]  sar_trial;
  logic [11:0]  result;
  logic         result_valid;
  int           clk_idx;
  int           error_cnt;
  int           tests_run;
  int           cycles;
  logic [11:0]  vin [8];
  logic [11:0]  exp_q [$];
  logic [2:0]   chans [4];

  // Comparator: input level at or above the trial code
  assign cmp_high = (vin[analog.mux_sel] >= sar_trial);

  touch_adc_serial_control #(.RES_BITS(12)) u_touch_adc_serial_control (
    .clk_sys(clk_sys), .srst(srst), .serial_clock_in(serial_clock_in), .cs_n(cs_n),
    .serial_data_in(serial_data_in), .serial_data_out(serial_data_out),
    .serial_data_out_oe(serial_data_out_oe), .busy(busy), .busy_oe(busy_oe),
    .touch_irq_n(touch_irq_n), .touch_irq_n_oe(touch_irq_n_oe), .pen_contact(pen_contact),
    .cmp_high(cmp_high), .analog(analog), .sar_trial(sar_trial), .result(result),
    .result_valid(result_valid));

  serial_host_model u_serial_host_model (
    .clk_sys(clk_sys), .serial_clock_in(serial_clock_in), .cs_n(cs_n),
    .serial_data_in(serial_data_in), .serial_data_out(serial_data_out),
    .serial_data_out_oe(serial_data_out_oe), .busy(busy), .busy_oe(busy_oe), .clk_idx(clk_idx));

  task automatic complete_run();
    $display("Comparisons %0d, mismatches %0d", tests_run, error_cnt);
    if (error_cnt == 0 && tests_run > 0) begin
      $display("SIMULATION PASSED");
    end else begin
      $display("SIMULATION FAILED");
    end
    $finish;
  endtask

  task automatic chk_vec(input logic [39:0] got, input logic [39:0] exp, input string what);
    tests_run++;
    if (got !== exp) begin
      error_cnt++;
      $display("ERROR %0t %s got %h expected %h", $time, what, got, exp);
    end
  endtask

  task automatic chk_ana(input analog_ctrl_s got, input analog_ctrl_s exp, input string what);
    chk_vec(40'(got), 40'(exp), what);
  endtask

  function automatic logic [7:0] cb(input logic [2:0] ch, input logic m8, input logic r,
                                    input logic [1:0] pd);
    return {1'b1, ch, m8, r, pd};
  endfunction

  // Top w bits of v placed so their MSB lands at serial clock n0
  function automatic logic [39:0] put(input logic [11:0] v, input int w, input int n0);
    return 40'(v >> (12 - w)) << (41 - n0 - w);
  endfunction

  function automatic analog_ctrl_s ana_exp(input logic [2:0] ch, input logic r, input logic conv);
    analog_ctrl_s a;
    logic         on;
    on = !(conv && r);
    a = '{mux_sel: ch, drive_x: on && ch == CH_Y_PLATE, drive_y: on && ch == CH_X_PLATE,
          y_neg_only: 1'b0, full_power: 1'b1, hold: conv,
          ref_route: (r || ch[1]) ? REF_VREF_GND : (ch == CH_X_PLATE ? REF_Y_PLATES : REF_X_PLATES)};
    return a;
  endfunction

  task automatic xfer(input logic [39:0] tx, input int n, input logic sel,
                      input logic [39:0] e_do, input logic [39:0] e_bz);
    logic [39:0] rx;
    logic [39:0] bz;
    u_serial_host_model.frame(tx, n, sel, rx, bz);
    if (sel) begin
      chk_vec(rx, e_do, "serial out");
      chk_vec(bz, e_bz, "busy");
    end
  endtask

  initial begin
    clk_sys = 1'b0;
    forever #20 clk_sys = ~clk_sys;
  end

  always @(posedge clk_sys) begin
    cycles++;
    if (cycles == 20000) begin
      error_cnt++;
      $display("ERROR %0t run did not finish", $time);
      complete_run();
    end
  end

  always @(negedge clk_sys) begin
    if (result_valid === 1'b1) begin
      chk_vec(40'(result), exp_q.size() > 0 ? 40'(exp_q.pop_front()) : 40'hX, "result");
    end
  end

  initial begin
    logic [2:0] ch;
    logic [1:0] pd;
    logic       r;
    logic       rp;
    chans = '{CH_X_PLATE, CH_Y_PLATE, CH_AUX_A, CH_AUX_B};
    // Reference bit arrives after the channel bits, so acquisition keeps the last accepted mode
    rp = 1'b1;
    vin = '{default: 12'h000};
    vin[CH_X_PLATE] = 12'hA5C;
    vin[CH_Y_PLATE] = 12'h3F1;
    vin[CH_AUX_A] = 12'h8A7;
    vin[CH_AUX_B] = 12'hFFF;
    srst = 1'b1;
    pen_contact = 1'b1;
    repeat (10) @(posedge clk_sys);
    @(negedge clk_sys);
    chk_ana(analog, ANALOG_RESET, "reset");
    chk_vec(40'({busy, touch_irq_n_oe, result_valid, touch_irq_n, result}), 40'h0, "reset");
    @(posedge clk_sys) srst <= 1'b0;
    for (int i = 0; i < 8; i++) begin
      ch = chans[i % 4];
      r = (i < 4);
      pd = {i[1], i[1] | i[0]};
      exp_q.push_back(vin[ch]);
      fork
        xfer({cb(ch, 1'b0, r, pd), 32'h0}, 24, 1'b1, put(vin[ch], 12, 9), put(12'hFFF, 12, 8));
        begin
          wait (clk_idx == 6);
          @(negedge clk_sys);
          chk_ana(analog, ana_exp(ch, rp, 1'b0), "acquire");
          wait (clk_idx == 10);
          @(negedge clk_sys);
          chk_ana(analog, ana_exp(ch, r, 1'b1), "convert");
        end
      join
      repeat (3) @(negedge clk_sys);
      chk_vec(40'({serial_data_out_oe, busy_oe}), 40'h0, "released");
      chk_vec(40'({touch_irq_n_oe, analog.y_neg_only}), 40'({pd == 0, pd == 0}), "idle");
      if (pd != 2'h2) begin
        chk_vec(40'(analog.full_power), 40'(pd == 2'h3), "power");
      end
      if (pd == 2'h0) begin
        @(posedge clk_sys) pen_contact <= 1'b0;
        repeat (3) @(negedge clk_sys);
        chk_vec(40'(touch_irq_n_oe), 40'h0, "pen");
        @(posedge clk_sys) pen_contact <= 1'b1;
      end
      rp = r;
    end
    exp_q.push_back(vin[CH_X_PLATE]);
    exp_q.push_back(vin[CH_Y_PLATE]);
    xfer({cb(CH_X_PLATE, 1'b0, 1'b1, 2'h3), 6'h00, cb(CH_Y_PLATE, 1'b0, 1'b1, 2'h3), 18'h0}, 36, 1'b1,
         put(vin[CH_X_PLATE], 12, 9) | put(vin[CH_Y_PLATE], 12, 23),
         put(12'hFFF, 12, 8) | put(12'hFFF, 12, 22));
    exp_q.push_back({vin[CH_AUX_A][11:4], 4'h0});
    exp_q.push_back({vin[CH_AUX_B][11:4], 4'h0});
    xfer({cb(CH_AUX_A, 1'b1, 1'b1, 2'h3), 2'h0, cb(CH_AUX_B, 1'b1, 1'b1, 2'h3), 22'h0}, 28, 1'b1,
         put(vin[CH_AUX_A], 8, 9) | put(vin[CH_AUX_B], 8, 19),
         put(12'hFFF, 8, 8) | put(12'hFFF, 8, 18));
    exp_q.push_back(vin[CH_AUX_B]);
    xfer({3'h0, cb(CH_AUX_B, 1'b0, 1'b1, 2'h3), 29'h0}, 27, 1'b1,
         put(vin[CH_AUX_B], 12, 12), put(12'hFFF, 12, 11));
    xfer({3'h7, 37'h0}, 3, 1'b1, 40'h0, 40'h0);
    xfer({8'hFF, 32'h0}, 8, 1'b0, 40'h0, 40'h0);
    exp_q.push_back(vin[CH_Y_PLATE]);
    xfer({cb(CH_Y_PLATE, 1'b0, 1'b0, 2'h0), 32'h0}, 24, 1'b1,
         put(vin[CH_Y_PLATE], 12, 9), put(12'hFFF, 12, 8));
    repeat (4) @(negedge clk_sys);
    chk_vec(40'(exp_q.size()), 40'h0, "results left");
    complete_run();
  end

endmodule // touch_adc_serial_control_tb_top

`default_nettype wire
